/* rtl/out_logic_pkg.sv */
// constants for the programmable output logic block
package out_logic_pkg;
  // configuration payload length and index width
  localparam int CFG_BYTES = 54;
  localparam logic [5:0] CFG_LAST_IDX = 6'h35;
  localparam logic [5:0] CFG_LEN = 6'h36;
  // payload indices of the header bytes
  localparam int IDX_PIN_CFG = 0;
  localparam int IDX_FLAGS = 1;
  localparam int IDX_HIRES = 2;
  localparam int IDX_MSEC = 3;
  localparam int IDX_PATH0_CFG = 4;
  localparam int IDX_PATH1_CFG = 5;
  // base index of each path's mask block
  localparam int IDX_PATH0_BASE = 6;
  localparam int IDX_PATH1_BASE = 30;
  // offsets inside a path block (second path lands on 0x2a/0x2e/0x32)
  localparam int OFS_STAT_MASK = 0;
  localparam int OFS_STAT_INV = 4;
  localparam int OFS_IN_MASK = 8;
  localparam int OFS_IN_INV = 12;
  localparam int OFS_OUT_MASK = 16;
  localparam int OFS_OUT_INV = 20;
  // second path register offsets
  localparam logic [7:0] SECOND_PATH_INPUT_INVERSION_MASK = 8'h2a;
  localparam logic [7:0] SECOND_PATH_OUTPUT_MASK = 8'h2e;
  localparam logic [7:0] SECOND_PATH_OUTPUT_MASK_RESERVED = 8'h30;
  localparam logic [7:0] SECOND_PATH_OUTPUT_INVERSION_MASK = 8'h32;
  localparam logic [7:0] SECOND_PATH_OUTPUT_INVERSION_RESERVED = 8'h34;
  // flag byte bits
  localparam int FLAG_ASSERT_DLY = 0;
  localparam int FLAG_DEASSERT_DLY = 1;
  localparam int FLAG_INVERT_OR = 2;
  localparam int FLAG_IGNORE_IN = 3;
  // path configuration byte fields
  localparam int PCFG_INVERT = 7;
  localparam int PCFG_SM_EN = 6;
  localparam int PCFG_TYPE_MSB = 5;
  // pin configuration mode field and the rejected input mode
  localparam int PIN_MODE_MSB = 7;
  localparam int PIN_MODE_LSB = 6;
  localparam logic [1:0] PIN_MODE_INPUT = 2'h0;
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int HIRES_UNIT_NS = 100000;
  localparam int MSEC_UNIT_NS = 1000000;
  localparam int HIRES_CYCLES = HIRES_UNIT_NS / CLK_PERIOD_NS;
  localparam int MSEC_CYCLES = MSEC_UNIT_NS / CLK_PERIOD_NS;
endpackage : out_logic_pkg

/* rtl/programmable_output_logic.sv */
// programmable output logic: two and paths, or stage, delay filter
// Summary of operation
// - reject configuration selecting input pin mode
// - delay assertion when assert delay enabled
// - delay deassertion when deassert delay enabled
// - invert or-stage result when bit set
// - ignore input changes while delay pending
// - invert an and path result when set
// - state machine mode uses one path at a time
// - state machine mode starts on path 0
// - high resolution delay is count times 100us
// - millisecond byte delays output updates
// - changes shorter than delay are filtered unless ignore is set
// - path byte: invert, type; sm enable in path 0 byte only
// - input mask bit includes that input
// - status mask bit includes that page
// - other outputs used by logical state
`timescale 1ns/1ps
module programmable_output_logic #(
  parameter int N_TYPES = 19,
  parameter int MSEC_CYC = out_logic_pkg::MSEC_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_cmd_start,
  input wire logic i_cmd_byte_valid,
  input wire logic [7:0] i_cmd_byte,
  input wire logic i_cmd_stop,
  input wire logic [31:0] i_logic_input,
  input wire logic [15:0] i_logic_output_state,
  input wire logic [N_TYPES*32-1:0] i_rail_status,
  output logic o_cmd_ack,
  output logic o_not_acknowledge,
  output logic o_logic_output,
  output logic o_delay_pending,
  output logic o_active_path,
  output logic [7:0] o_pin_config
);

  typedef struct packed {
    logic [out_logic_pkg::CFG_BYTES*8-1:0] shadow;
    logic [out_logic_pkg::CFG_BYTES*8-1:0] cfg;
    logic [5:0] idx;
    logic overflow;
    logic ack;
    logic not_acknowledge;
    logic [31:0] in_meta;
    logic [31:0] in_sync;
    logic out;
    logic pend;
    logic latched;
    logic [31:0] cnt;
    logic use_p1;
  } state_t;

  state_t s;
  state_t next_s;

  // byte and word fields out of a payload image, least byte first
  function automatic logic [7:0] get8(
    input logic [out_logic_pkg::CFG_BYTES*8-1:0] img, input int idx);
    return img[idx*8 +: 8];
  endfunction : get8

  function automatic logic [31:0] get32(
    input logic [out_logic_pkg::CFG_BYTES*8-1:0] img, input int idx);
    return img[idx*8 +: 32];
  endfunction : get32

  // one and path: every masked term, after its own inversion
  function automatic logic and_path(
    input logic [out_logic_pkg::CFG_BYTES*8-1:0] img,
    input int base,
    input logic [31:0] stat,
    input logic [31:0] pins,
    input logic [15:0] outs);
    logic [31:0] sm;
    logic [31:0] si;
    logic [31:0] im;
    logic [31:0] ii;
    logic [15:0] om;
    logic [15:0] oi;
    sm = get32(img, base + out_logic_pkg::OFS_STAT_MASK);
    si = get32(img, base + out_logic_pkg::OFS_STAT_INV);
    im = get32(img, base + out_logic_pkg::OFS_IN_MASK);
    ii = get32(img, base + out_logic_pkg::OFS_IN_INV);
    om = 16'(get32(img, base + out_logic_pkg::OFS_OUT_MASK));
    oi = 16'(get32(img, base + out_logic_pkg::OFS_OUT_INV));
    return (&(~sm | (stat ^ si))) &
           (&(~im | (pins ^ ii))) &
           (&(~om | (outs ^ oi)));
  endfunction : and_path

  // status vector for a path's selected type; unknown types read false
  function automatic logic [31:0] sel_status(
    input logic [N_TYPES*32-1:0] all, input logic [7:0] pcfg);
    int t;
    t = int'(pcfg[out_logic_pkg::PCFG_TYPE_MSB:0]);
    if (t < N_TYPES) begin
      return all[t*32 +: 32];
    end
    return 32'h0;
  endfunction : sel_status

  logic [7:0] pin_cfg;
  logic [7:0] flags;
  logic [7:0] p0_cfg;
  logic [7:0] p1_cfg;
  logic p0;
  logic p1;
  logic sm_mode;
  logic combined;
  logic target;
  logic dly_en;
  logic ignore_in;
  logic [31:0] total;
  logic bad_cmd;
  logic [7:0] shadow_pin;

  // decode the live configuration and evaluate both paths
  always_comb begin
    pin_cfg = get8(s.cfg, out_logic_pkg::IDX_PIN_CFG);
    flags = get8(s.cfg, out_logic_pkg::IDX_FLAGS);
    p0_cfg = get8(s.cfg, out_logic_pkg::IDX_PATH0_CFG);
    p1_cfg = get8(s.cfg, out_logic_pkg::IDX_PATH1_CFG);
    p0 = and_path(s.cfg, out_logic_pkg::IDX_PATH0_BASE,
                  sel_status(i_rail_status, p0_cfg), s.in_sync,
                  i_logic_output_state)
         ^ p0_cfg[out_logic_pkg::PCFG_INVERT];
    p1 = and_path(s.cfg, out_logic_pkg::IDX_PATH1_BASE,
                  sel_status(i_rail_status, p1_cfg), s.in_sync,
                  i_logic_output_state)
         ^ p1_cfg[out_logic_pkg::PCFG_INVERT];
    sm_mode = p0_cfg[out_logic_pkg::PCFG_SM_EN];
    // one path at a time in state machine mode, otherwise or of both
    combined = sm_mode ? (s.use_p1 ? p1 : p0) : (p0 | p1);
    target = combined ^ flags[out_logic_pkg::FLAG_INVERT_OR];
    dly_en = target ? flags[out_logic_pkg::FLAG_ASSERT_DLY]
                    : flags[out_logic_pkg::FLAG_DEASSERT_DLY];
    ignore_in = flags[out_logic_pkg::FLAG_IGNORE_IN];
    // 32 bits hold the worst case 255 * 2500 + 255 * 25000 cycles
    total = 32'(get8(s.cfg, out_logic_pkg::IDX_HIRES)) *
            32'(out_logic_pkg::HIRES_CYCLES) +
            32'(get8(s.cfg, out_logic_pkg::IDX_MSEC)) * 32'(MSEC_CYC);
    shadow_pin = get8(s.shadow, out_logic_pkg::IDX_PIN_CFG);
    // a pin mode of input refuses the whole block
    bad_cmd = s.overflow || (s.idx != out_logic_pkg::CFG_LEN) ||
              (shadow_pin[out_logic_pkg::PIN_MODE_MSB:
                          out_logic_pkg::PIN_MODE_LSB]
               == out_logic_pkg::PIN_MODE_INPUT);
  end

  // next state: command capture, input sync, path select, delay filter
  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    next_s.not_acknowledge = 1'b0;
    next_s.in_meta = i_logic_input;
    next_s.in_sync = s.in_meta;
    if (i_cmd_start) begin
      next_s.idx = 6'h0;
      next_s.overflow = 1'b0;
    end else if (i_cmd_byte_valid) begin
      if (s.idx <= out_logic_pkg::CFG_LAST_IDX) begin
        next_s.shadow[s.idx*8 +: 8] = i_cmd_byte;
        next_s.idx = s.idx + 6'h1;
      end else begin
        next_s.overflow = 1'b1;
      end
    end
    // a rejected block leaves the live configuration untouched
    if (i_cmd_stop && !i_cmd_start) begin
      if (bad_cmd) begin
        next_s.not_acknowledge = 1'b1;
      end else begin
        next_s.cfg = s.shadow;
        next_s.ack = 1'b1;
      end
    end
    // after a true result stay on path 0, after false move to path 1
    next_s.use_p1 = sm_mode && !target;
    if (!s.pend) begin
      if (target != s.out) begin
        if (dly_en && total != 32'h0) begin
          next_s.pend = 1'b1;
          next_s.latched = target;
          next_s.cnt = total - 32'h1;
        end else begin
          next_s.out = target;
        end
      end
    end else if (!ignore_in && target == s.out) begin
      next_s.pend = 1'b0;
    end else if (s.cnt == 32'h0) begin
      // with ignore set the value seen at the start is applied
      next_s.out = ignore_in ? s.latched : target;
      next_s.pend = 1'b0;
    end else begin
      next_s.cnt = s.cnt - 32'h1;
    end
  end

  // single state register, synchronous active low reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_cmd_ack = s.ack;
  assign o_not_acknowledge = s.not_acknowledge;
  assign o_logic_output = s.out;
  assign o_delay_pending = s.pend;
  assign o_active_path = s.use_p1;
  assign o_pin_config = pin_cfg;

  a_not_acknowledge_input_mode: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_stop && !i_cmd_start && shadow_pin[7:6] == 2'h0
    |=> o_not_acknowledge && !o_cmd_ack && $stable(s.cfg))
    else $error("input pin mode not refused");
  a_assert_waits: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !s.pend && target && !s.out && flags[0] && total > 32'h1
    |=> s.pend && !o_logic_output ##1 !o_logic_output)
    else $error("assert delay skipped");
  a_deassert_waits: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !s.pend && !target && s.out && flags[1] && total > 32'h1
    |=> o_logic_output && s.pend)
    else $error("deassert delay skipped");
  a_no_delay_follow: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !s.pend && target != s.out && !dly_en
    |=> o_logic_output == $past(target))
    else $error("undelayed output did not follow");
  a_ignore_applies: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s.pend && ignore_in && s.cnt == 32'h0
    |=> !s.pend && o_logic_output == $past(s.latched))
    else $error("latched value not applied");
  a_short_filtered: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s.pend && !ignore_in && target == s.out
    |=> !s.pend && $stable(o_logic_output))
    else $error("short change reached output");
  a_sm_path_select: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    sm_mode |=> o_active_path == !$past(target))
    else $error("wrong path in state machine mode");
  a_sm_start_p0: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !sm_mode |=> !o_active_path)
    else $error("path 1 selected outside state machine mode");
  a_delay_count: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !s.pend && target != s.out && dly_en && total != 32'h0
    |=> s.cnt == $past(total) - 32'h1)
    else $error("delay count not loaded from configuration");

endmodule : programmable_output_logic

/* sim/cfg_host.sv */
// host model that writes the output logic configuration block
`timescale 1ns/1ps
module cfg_host (
  input wire logic i_clk,
  output logic o_start,
  output logic o_valid,
  output logic [7:0] o_byte,
  output logic o_stop
);
  logic [7:0] img [54];

  // idle handshake at time zero
  initial begin
    o_start = 1'b0;
    o_valid = 1'b0;
    o_byte = 8'h00;
    o_stop = 1'b0;
  end

  // multi-byte fields go out least significant byte first
  task automatic put(input int idx, input logic [31:0] v, input int n);
    for (int k = 0; k < n; k++) img[idx+k] = v[8*k +: 8];
  endtask : put

  // build a block; reserved bytes stay zero
  task automatic setup(input logic [7:0] pin, fl, ms, p0, p1,
      input logic [31:0] m0, i0, m1, i1, input logic [15:0] om, oi);
    foreach (img[k]) img[k] = 8'h00;
    put(0, {ms, 8'h00, fl, pin}, 4);
    img[4] = p0;
    img[5] = p1;
    put(14, m0, 4);
    put(18, i0, 4);
    put(38, m1, 4);
    put(42, i1, 4);
    put(46, {16'h0, om}, 2);
    put(50, {16'h0, oi}, 2);
  endtask : setup

  // start, 54 bytes back to back, stop; returns just after the answer edge
  task automatic send();
    @(posedge i_clk);
    o_start <= 1'b1;
    for (int i = 0; i < 54; i++) begin
      @(posedge i_clk);
      o_start <= 1'b0;
      o_valid <= 1'b1;
      o_byte <= img[i];
    end
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_byte <= ~img[53]; // released line shows no stale byte
    o_stop <= 1'b1;
    @(posedge i_clk);
    o_stop <= 1'b0;
    #1;
  endtask : send
endmodule : cfg_host

/* sim/tb_top.sv */
// self-checking bench for the programmable output logic
`timescale 1ns/1ps
module tb_top;
  localparam int MS = 10;
  // one high resolution unit plus one millisecond unit, in cycles
  localparam int DLY = out_logic_pkg::HIRES_CYCLES + MS;
  logic clk, rst_b, start, valid, stop, ack, not_acknowledge, out, pend, path;
  logic [7:0] byte_d, pin_cfg;
  logic [31:0] pins;
  logic [15:0] outs;
  logic [19*32-1:0] rail;
  int failures, checks_done;

  cfg_host i_cfg_host (.i_clk(clk), .o_start(start), .o_valid(valid),
    .o_byte(byte_d), .o_stop(stop));
  // short millisecond unit keeps delay runs brief
  programmable_output_logic #(.N_TYPES(19), .MSEC_CYC(MS))
    i_programmable_output_logic (.i_clk(clk), .i_rst_b(rst_b),
    .i_cmd_start(start), .i_cmd_byte_valid(valid), .i_cmd_byte(byte_d),
    .i_cmd_stop(stop), .i_logic_input(pins), .i_logic_output_state(outs),
    .i_rail_status(rail), .o_cmd_ack(ack), .o_not_acknowledge(not_acknowledge),
    .o_logic_output(out), .o_delay_pending(pend), .o_active_path(path),
    .o_pin_config(pin_cfg));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic chk(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // path 0 inverted empty (false); path 1 = not pin 3 and not output 2
  task automatic t_logic();
    for (int j = 0; j < 2; j++) begin
      i_cfg_host.setup(8'h40, {5'h0, j[0], 2'h0}, 8'h00, 8'h80, 8'h00,
        32'h0, 32'h0, 32'h8, 32'h8, 16'h4, 16'h4);
      i_cfg_host.send();
      chk("answer", {ack, not_acknowledge}, 8'h02);
      chk("pin config", pin_cfg, 8'h40);
      for (int k = 0; k < 8; k++) begin
        cyc(1);
        pins <= {28'h0, k[0], 2'h0, k[2]}; // pin 0 is unmasked
        outs <= {13'h0, k[1], 2'h0};
        cyc(5);
        @(negedge clk);
        chk("and or", out, (!k[0] && !k[1]) ^ j[0]);
      end
    end
  endtask : t_logic

  // input pin mode must be refused with config left alone
  task automatic t_reject();
    i_cfg_host.setup(8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      32'h0, 32'h0, 32'h0, 32'h0, 16'h0, 16'h0);
    i_cfg_host.send();
    chk("answer", {ack, not_acknowledge}, 8'h01);
    chk("pin config", pin_cfg, 8'h40);
  endtask : t_reject

  // four-cycle pulse on pin 3 against a one unit assert delay
  task automatic pulse(input logic [7:0] fl, output logic hi);
    cyc(1);
    pins <= 32'h0;
    i_cfg_host.setup(8'h40, fl, 8'h01, 8'h80, 8'h00,
      32'h0, 32'h0, 32'h8, 32'h0, 16'h0, 16'h0);
    i_cfg_host.send();
    cyc(4);
    pins <= 32'h8;
    cyc(4);
    pins <= 32'h0;
    hi = 1'b0;
    repeat (24) begin
      @(negedge clk);
      hi |= out;
    end
  endtask : pulse

  task automatic t_delay();
    logic hi;
    pulse(8'h01, hi);
    chk("short pulse", hi, 8'h00);
    pulse(8'h09, hi);
    chk("ignored drop", hi, 8'h01);
    cyc(1);
    pins <= 32'h8;
    cyc(8);
    @(negedge clk);
    chk("held", {pend, out}, 8'h02);
    cyc(8);
    @(negedge clk);
    chk("asserted", {pend, out}, 8'h01);
    cyc(1);
    pins <= 32'h0;
    cyc(4);
    @(negedge clk);
    chk("no deassert delay", out, 8'h00);
    // deassert delay only, high resolution count 1 plus ms byte 1
    i_cfg_host.setup(8'h40, 8'h02, 8'h01, 8'h80, 8'h00,
      32'h0, 32'h0, 32'h8, 32'h0, 16'h0, 16'h0);
    i_cfg_host.img[2] = 8'h01;
    i_cfg_host.send();
    cyc(1);
    pins <= 32'h8;
    cyc(4);
    @(negedge clk);
    chk("no assert delay", out, 8'h01);
    cyc(1);
    pins <= 32'h0;
    // two sync stages, the delay itself, then the output register
    cyc(DLY + 2);
    @(negedge clk);
    chk("deassert held", {pend, out}, 8'h03);
    cyc(1);
    @(negedge clk);
    chk("deasserted", {pend, out}, 8'h00);
  endtask : t_delay

  // path 0 = a or b while true, path 1 = a and b while false
  task automatic t_sm();
    int seq[5] = '{0, 1, 3, 1, 0};
    logic [4:0] ex = 5'b01100;
    i_cfg_host.setup(8'h40, 8'h00, 8'h00, 8'hc0, 8'h00,
      32'h3, 32'h3, 32'h3, 32'h0, 16'h0, 16'h0);
    i_cfg_host.send();
    for (int k = 0; k < 5; k++) begin
      cyc(1);
      pins <= seq[k];
      cyc(6);
      @(negedge clk);
      chk("sm out", out, ex[k]);
      chk("sm path", path, !ex[k]);
    end
  endtask : t_sm

  // path 1 = inverted page 4 status of type 2; type 0 must not count
  task automatic t_status();
    i_cfg_host.setup(8'h40, 8'h00, 8'h00, 8'h80, 8'h02,
      32'h0, 32'h0, 32'h0, 32'h0, 16'h0, 16'h0);
    i_cfg_host.put(30, 32'h10, 4); // status mask
    i_cfg_host.put(34, 32'h10, 4); // status inversion
    i_cfg_host.send();
    cyc(2);
    @(negedge clk);
    chk("status clear", out, 8'h01);
    cyc(1);
    rail[4] <= 1'b1;
    cyc(2);
    @(negedge clk);
    chk("other type", out, 8'h01);
    cyc(1);
    rail[2*32+4] <= 1'b1;
    cyc(2);
    @(negedge clk);
    chk("status set", out, 8'h00);
    cyc(1);
    rail <= '0;
  endtask : t_status

  initial begin
    failures = 0;
    checks_done = 0;
    rst_b = 1'b0;
    pins = 32'h0;
    outs = 16'h0;
    rail = '0;
    cyc(10);
    rst_b <= 1'b1;
    t_logic();
    t_reject();
    t_delay();
    t_sm();
    t_status();
    report_and_stop();
  end
endmodule : tb_top
